// >>> mml_phy_model.sv
// Behavioural phy management side: shifts in data, answers, shows link
`timescale 1ns/1ns
module mml_phy_model
(
  input  wire logic       mdc_in,      // Clock wire level
  input  wire logic       mdio_in,     // Data wire level
  input  wire logic       drv_in,      // Bench asks phy to drive data
  input  wire logic       bit_in,      // Value the phy drives
  input  wire logic       link_in,     // Bench link state
  output logic            mdio_out,    // Data drive value
  output logic            mdio_oe_out, // Data drive enable
  output logic            link_out,    // Link pin, steady while up
  output logic      [7:0] cap_out      // Bits seen on clock rises
);
  // ******************************************************************
  // Link pin and data answer
  // ******************************************************************
  // Level only, never blinks while the link is up
  assign link_out    = link_in;
  assign mdio_oe_out = drv_in;
  assign mdio_out    = bit_in;
  // Frames shift in msb first on clock rises
  initial cap_out = 8'h00;
  always @(posedge mdc_in)
    cap_out <= {cap_out[6:0], mdio_in};
endmodule

// >>> mml_pkg.sv
// Package: register map, field positions and reset values for the block
package mml_pkg;

  // ********************************************************************
  // Register offsets (byte addresses, one aligned word each)
  // ********************************************************************
  localparam logic [11:0] MML_CTRL_OFS   = 12'h000; // Management control
  localparam logic [11:0] MML_POLL_OFS   = 12'h004; // Link poll / mode select
  localparam logic [11:0] MML_MANUAL_OFS = 12'h008; // Manual pin access
  localparam logic [11:0] MML_LINK_OFS   = 12'h00C; // Link monitor status

  // ********************************************************************
  // Field positions
  // ********************************************************************
  localparam int MML_CTRL_EN_BIT     = 0;  // Automatic engine enable
  localparam int MML_POLL_MAN_BIT    = 0;  // Manual mode select
  localparam int MML_POLL_MON_BIT    = 1;  // Auto link monitor enable
  localparam int MML_MAN_CLK_BIT     = 0;  // Clock pin drive value
  localparam int MML_MAN_DOUT_BIT    = 1;  // Data pin drive value
  localparam int MML_MAN_DOE_BIT     = 2;  // Data pin direction, 1 = out
  localparam int MML_MAN_DIN_BIT     = 3;  // Sampled data pin level
  localparam int MML_MAN_CLKIN_BIT   = 4;  // Sampled clock pin level
  localparam int MML_LINK_UP_BIT     = 0;  // Current link state
  localparam int MML_LINK_CHG_BIT    = 1;  // Sticky link change flag

  // ********************************************************************
  // Reset values
  // ********************************************************************
  localparam logic [31:0] MML_CTRL_RST   = 32'h0000_0000;
  localparam logic [31:0] MML_POLL_RST   = 32'h0000_0000;
  localparam logic [31:0] MML_MANUAL_RST = 32'h0000_0000;
  localparam logic [31:0] MML_RDZERO     = 32'h0000_0000;

endpackage

// >>> mml_top.sv
// Module: manual pin access and link monitor for the management interface
`timescale 1ns/1ns
// ********************************************************************
// Summary of operation
// (RL1) Software drives and samples pins via register
// (RL2) Software keeps engine enable at zero first
// (RL3) Manual select bit hands pins to software
// (RL4) Pad muxing still routes pins to this block
// (RL5) Hardware polls link from dedicated status pin
// (RL6) Phy link output stays steady while up
// (RL7) Link monitor works with engine disabled
// (RL8) Manual reads report data pin; input releases
// ********************************************************************
module mml_top
  import mml_pkg::*;
(
  input  wire logic        clk_sys_in,    // Functional clock, 250 MHz
  input  wire logic        rst_n_in,      // Synchronous reset, active low
  input  wire logic        psel_in,       // APB select
  input  wire logic        penable_in,    // APB access phase
  input  wire logic        pwrite_in,     // APB direction, 1 = write
  input  wire logic [11:0] paddr_in,      // APB byte address
  input  wire logic [31:0] pwdata_in,     // APB write data
  input  wire logic [3:0]  pstrb_in,      // APB byte strobes
  output logic      [31:0] prdata_out,    // APB read data
  output logic             pready_out,    // APB ready
  output logic             pslverr_out,   // APB error on unmapped address
  input  wire logic        mdc_in,        // Clock pad level
  output logic             mdc_out,       // Clock pad drive value
  output logic             mdc_oe_out,    // Clock pad drive enable
  input  wire logic        mdio_in,       // Data pad level
  output logic             mdio_out,      // Data pad drive value
  output logic             mdio_oe_out,   // Data pad drive enable
  input  wire logic        phy_link_status_input_in, // Link pin from phy
  output logic             link_up_out,   // Monitored link state
  output logic             engine_en_out  // Automatic engine enable level
);

  // ********************************************************************
  // Register state
  // ********************************************************************
  logic        ctrl_en_r,   ctrl_en_nxt;    // Automatic engine enable
  logic        man_sel_r,   man_sel_nxt;    // Manual mode select
  logic        mon_en_r,    mon_en_nxt;     // Auto link monitor enable
  logic [2:0]  man_r,       man_nxt;        // Manual clk, dout, doe
  logic        link_r,      link_nxt;       // Debounce-free link state
  logic        chg_r,       chg_nxt;        // Sticky link change
  logic [31:0] rdata_r,     rdata_nxt;      // Read data register
  logic        ready_r,     ready_nxt;      // Ready pulse
  logic        err_r,       err_nxt;        // Error pulse
  logic        mdc_r,       mdc_nxt;        // Clock pad out
  logic        mdc_oe_r,    mdc_oe_nxt;     // Clock pad enable
  logic        mdo_r,       mdo_nxt;        // Data pad out
  logic        mdo_oe_r,    mdo_oe_nxt;     // Data pad enable

  // ********************************************************************
  // Pin synchronisers, two flops before any reader
  // ********************************************************************
  logic [2:0] sync1_r; // First stage, read only by sync2_r
  logic [2:0] sync2_r; // Second stage: {link, mdc, mdio}

  // Plain two-stage capture of asynchronous pad levels
  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
    begin
      sync1_r <= 3'h0;
      sync2_r <= 3'h0;
    end
    else
    begin
      sync1_r <= {phy_link_status_input_in, mdc_in, mdio_in};
      sync2_r <= sync1_r;
    end
  end

  logic link_s;  // Synchronised link pin
  logic mdc_s;   // Synchronised clock pad
  logic mdio_s;  // Synchronised data pad
  assign link_s = sync2_r[2];
  assign mdc_s  = sync2_r[1];
  assign mdio_s = sync2_r[0];

  // ********************************************************************
  // APB slave and next-state logic
  // ********************************************************************
  logic acc;   // Access phase seen; pready answers on the next cycle
  logic wr;    // Write taken this cycle
  logic hit;   // Address mapped
  logic manual_on; // Manual mode owns the pads

  assign acc = psel_in && penable_in && !ready_r;
  assign wr  = acc && pwrite_in && hit && pstrb_in[0];
  assign manual_on = man_sel_r;

  // Address map check, kept apart from the next-state process so that
  // the write strobe built from it never feeds back into its own source
  always_comb
  begin
    unique case (paddr_in)
      MML_CTRL_OFS, MML_POLL_OFS, MML_MANUAL_OFS, MML_LINK_OFS:
        hit = 1'b1;
      default:
        hit = 1'b0;
    endcase
  end

  // Decode, writes, read mux and pad steering
  always_comb
  begin
    ctrl_en_nxt = ctrl_en_r;
    man_sel_nxt = man_sel_r;
    mon_en_nxt  = mon_en_r;
    man_nxt     = man_r;
    rdata_nxt   = rdata_r;
    ready_nxt   = acc;
    err_nxt     = 1'b0;
    // Unknown offsets get pslverr and read zero
    if (acc && !hit)
    begin
      err_nxt   = 1'b1;
      rdata_nxt = MML_RDZERO;
    end
    if (wr)
    begin
      // Only byte lane 0 carries fields; other lanes ignored
      unique case (paddr_in)
        MML_CTRL_OFS:
          ctrl_en_nxt = pwdata_in[MML_CTRL_EN_BIT];
        MML_POLL_OFS:
        begin
          man_sel_nxt = pwdata_in[MML_POLL_MAN_BIT]; // RL3
          mon_en_nxt  = pwdata_in[MML_POLL_MON_BIT];
        end
        MML_MANUAL_OFS:
          man_nxt = {pwdata_in[MML_MAN_DOE_BIT],
                     pwdata_in[MML_MAN_DOUT_BIT],
                     pwdata_in[MML_MAN_CLK_BIT]}; // RL1
        default:
          man_nxt = man_r;
      endcase
    end
    if (acc && hit && !pwrite_in)
    begin
      rdata_nxt = MML_RDZERO;
      unique case (paddr_in)
        MML_CTRL_OFS:
          rdata_nxt[MML_CTRL_EN_BIT] = ctrl_en_r;
        MML_POLL_OFS:
        begin
          rdata_nxt[MML_POLL_MAN_BIT] = man_sel_r;
          rdata_nxt[MML_POLL_MON_BIT] = mon_en_r;
        end
        MML_MANUAL_OFS:
        begin
          rdata_nxt[MML_MAN_CLK_BIT]   = man_r[0];
          rdata_nxt[MML_MAN_DOUT_BIT]  = man_r[1];
          rdata_nxt[MML_MAN_DOE_BIT]   = man_r[2];
          rdata_nxt[MML_MAN_DIN_BIT]   = mdio_s; // RL8
          rdata_nxt[MML_MAN_CLKIN_BIT] = mdc_s;  // RL1
        end
        default:
        begin
          rdata_nxt[MML_LINK_UP_BIT]  = link_r;
          rdata_nxt[MML_LINK_CHG_BIT] = chg_r;
        end
      endcase
    end
    // Pads follow manual bits only in manual mode; the automatic engine
    // is not built here, so otherwise the pads are released.
    mdc_nxt    = manual_on ? man_r[0] : 1'b0;     // RL3
    mdc_oe_nxt = manual_on;                       // RL1
    mdo_nxt    = manual_on ? man_r[1] : 1'b0;
    mdo_oe_nxt = manual_on && man_r[2];           // RL8
  end

  // ********************************************************************
  // Link monitor, independent of engine enable and manual mode
  // ********************************************************************
  logic clr_chg; // Software write of one to the change flag
  assign clr_chg = wr && (paddr_in == MML_LINK_OFS)
                   && pwdata_in[MML_LINK_CHG_BIT];

  // Tracks the pin; set of the change flag wins over a clear
  always_comb
  begin
    link_nxt = mon_en_r ? link_s : 1'b0;          // RL5 RL7
    chg_nxt  = chg_r;
    if (clr_chg)
      chg_nxt = 1'b0;
    if (link_nxt != link_r)
      chg_nxt = 1'b1;                             // RL5
  end

  // Register all state
  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
    begin
      ctrl_en_r <= MML_CTRL_RST[MML_CTRL_EN_BIT];
      man_sel_r <= MML_POLL_RST[MML_POLL_MAN_BIT];
      mon_en_r  <= MML_POLL_RST[MML_POLL_MON_BIT];
      man_r     <= MML_MANUAL_RST[2:0];
      link_r    <= 1'b0;
      chg_r     <= 1'b0;
      rdata_r   <= MML_RDZERO;
      ready_r   <= 1'b0;
      err_r     <= 1'b0;
      mdc_r     <= 1'b0;
      mdc_oe_r  <= 1'b0;
      mdo_r     <= 1'b0;
      mdo_oe_r  <= 1'b0;
    end
    else
    begin
      ctrl_en_r <= ctrl_en_nxt;
      man_sel_r <= man_sel_nxt;
      mon_en_r  <= mon_en_nxt;
      man_r     <= man_nxt;
      link_r    <= link_nxt;
      chg_r     <= chg_nxt;
      rdata_r   <= rdata_nxt;
      ready_r   <= ready_nxt;
      err_r     <= err_nxt;
      mdc_r     <= mdc_nxt;
      mdc_oe_r  <= mdc_oe_nxt;
      mdo_r     <= mdo_nxt;
      mdo_oe_r  <= mdo_oe_nxt;
    end
  end

  // ********************************************************************
  // Outputs, all from flops
  // ********************************************************************
  assign prdata_out    = rdata_r;
  assign pready_out    = ready_r;
  assign pslverr_out   = err_r;
  assign mdc_out       = mdc_r;
  assign mdc_oe_out    = mdc_oe_r;
  assign mdio_out      = mdo_r;
  assign mdio_oe_out   = mdo_oe_r;
  assign link_up_out   = link_r;
  assign engine_en_out = ctrl_en_r;

  // ********************************************************************
  // Assertions
  // ********************************************************************
  a_manual_clk_drive: assert property ( // RL1
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    (man_sel_r && man_r[0]) |=> (mdc_out && mdc_oe_out))
    else $error("clock pad not driven from manual bit");

  a_manual_gate: assert property ( // RL3
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    !man_sel_r |=> (!mdc_oe_out && !mdio_oe_out))
    else $error("pads driven outside manual mode");

  a_data_release: assert property ( // RL8
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    (man_sel_r && !man_r[2]) |=> !mdio_oe_out)
    else $error("data pad not released in input mode");

  a_data_drive: assert property ( // RL8
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    (man_sel_r && man_r[2]) |=> (mdio_oe_out && mdio_out == $past(man_r[1])))
    else $error("data pad not driven with manual value");

  a_link_follow: assert property ( // RL5
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    (mon_en_r && $stable(link_s)) |=> (link_up_out == $past(link_s)))
    else $error("link output does not follow pin");

  a_link_no_engine: assert property ( // RL7
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    (mon_en_r && !ctrl_en_r && $rose(link_s)) |=> link_up_out)
    else $error("link monitor stalled with engine off");

  a_link_change: assert property ( // RL5
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    $changed(link_up_out) |-> chg_r)
    else $error("link change not flagged");

  a_apb_ready: assert property ( // RL1
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    (psel_in && penable_in && !pready_out) |=> pready_out ##1 !pready_out)
    else $error("apb ready not a one cycle answer");

endmodule

// >>> tb_mdio_manual_and_link_monitor.sv
// Testbench: manual pin access and link monitor over APB
`timescale 1ns/1ns
module tb_mdio_manual_and_link_monitor;
  import mml_pkg::*;
  logic        clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwd = 32'h0, prd, rd;
  logic        rdy, err, slv, mdc_o, mdc_e, dio_o, dio_e, lup, een;
  logic        p_drv = 0, p_bit = 0, p_link = 0, p_o, p_e, lnk;
  logic [7:0]  cap;
  logic [7:0]  tx = 8'hA5;   // Byte bit-banged to the phy, msb first
  logic [3:0]  pstb = 4'hF;  // Byte strobes, lane 0 gates every write
  wire         mdc_w, dio_w;
  int          n_mismatch = 0, cmp_count = 0, i;
  // Wire levels: clock pulled low, data pulled up when nobody drives
  assign mdc_w = mdc_e ? mdc_o : 1'b0;
  assign dio_w = dio_e ? dio_o : (p_e ? p_o : 1'b1);
  always #2 clk = ~clk;
  // Pads routed straight to the block, as in normal operation
  mml_top dut (.clk_sys_in(clk), .rst_n_in(rst_n), .psel_in(psel),
    .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr),
    .pwdata_in(pwd), .pstrb_in(pstb), .prdata_out(prd),
    .pready_out(rdy), .pslverr_out(slv), .mdc_in(mdc_w),
    .mdc_out(mdc_o), .mdc_oe_out(mdc_e), .mdio_in(dio_w),
    .mdio_out(dio_o), .mdio_oe_out(dio_e),
    .phy_link_status_input_in(lnk), .link_up_out(lup),
    .engine_en_out(een));
  mml_phy_model phy (.mdc_in(mdc_w), .mdio_in(dio_w), .drv_in(p_drv),
    .bit_in(p_bit), .link_in(p_link), .mdio_out(p_o),
    .mdio_oe_out(p_e), .link_out(lnk), .cap_out(cap));
  // One compare point, counts and reports
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] e);
    cmp_count++;
    if (seen !== e)
    begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, e, seen);
    end
  endtask
  // APB transfer, held until ready is sampled high
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1; pwr <= w; paddr <= a; pwd <= d;
    @(posedge clk);
    pen <= 1;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (rdy !== 1'b1 && n < 40);
    if (n >= 40) chk("pready", 0, 1);
    rd = prd;
    err = slv;
    psel <= 0; pen <= 0;
  endtask
  // Read and compare selected bits
  task rchk(input string nm, input logic [11:0] a, input logic [31:0] m,
            input logic [31:0] e);
    apb(0, a, 32'h0);
    chk(nm, rd & m, e);
  endtask
  // Pads follow writes two edges late; allow margin
  task settle();
    repeat (6) @(posedge clk);
  endtask
  task close_out();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Watchdog far beyond the sequence length
  initial
  begin
    #100000;
    n_mismatch++;
    close_out();
  end
  // ******************************************************************
  // Test sequence
  // ******************************************************************
  initial
  begin
    repeat (8) @(posedge clk);
    rst_n <= 1;
    rchk("ctrl", MML_CTRL_OFS, 32'hFFFF_FFFF, MML_CTRL_RST);
    rchk("poll", MML_POLL_OFS, 32'hFFFF_FFFF, MML_POLL_RST);
    rchk("unmapped", 12'h010, 32'hFFFF_FFFF, MML_RDZERO);
    chk("slverr", err, 1);
    apb(1, MML_CTRL_OFS, 32'h1);
    settle();
    chk("engine on", een, 1);
    apb(1, MML_CTRL_OFS, 32'h0);
    settle();
    chk("engine off", een, 0);
    // A write without lane 0 is answered but must leave the engine off
    pstb <= 4'h0;
    apb(1, MML_CTRL_OFS, 32'h1);
    pstb <= 4'hF;
    settle();
    chk("strobe off", een, 0);
    // Manual bits stay off the pads until manual select is set
    apb(1, MML_MANUAL_OFS, 32'h7);
    settle();
    chk("released", {mdc_e, dio_e}, 0);
    apb(1, MML_POLL_OFS, 32'h1);
    settle();
    chk("manual pads", {mdc_e, mdc_o, dio_e, dio_o}, 4'hF);
    // Bit-bang one byte, data set before each clock rise
    for (i = 7; i >= 0; i--)
    begin
      apb(1, MML_MANUAL_OFS, {29'h0, 1'b1, tx[i], 1'b0});
      apb(1, MML_MANUAL_OFS, {29'h0, 1'b1, tx[i], 1'b1});
    end
    settle();
    chk("phy byte", cap, 8'hA5);
    // Input direction releases data; reads show the wire
    apb(1, MML_MANUAL_OFS, 32'h1);
    settle();
    chk("data oe", dio_e, 0);
    rchk("pads up", MML_MANUAL_OFS, 32'h18, 32'h18);
    p_drv <= 1;
    settle();
    rchk("phy low", MML_MANUAL_OFS, 32'h8, 32'h0);
    p_bit <= 1;
    settle();
    rchk("phy high", MML_MANUAL_OFS, 32'h8, 32'h8);
    // Link monitor with the engine left off
    apb(1, MML_POLL_OFS, 32'h3);
    p_link <= 1;
    settle();
    chk("link up", lup, 1);
    rchk("link reg", MML_LINK_OFS, 32'h3, 32'h3);
    apb(1, MML_LINK_OFS, 32'h2);
    rchk("chg clear", MML_LINK_OFS, 32'h3, 32'h1);
    p_link <= 0;
    settle();
    chk("link down", lup, 0);
    apb(1, MML_POLL_OFS, 32'h0);
    settle();
    chk("auto release", {mdc_e, dio_e}, 0);
    close_out();
  end
endmodule
